// ---- rtl/mcrr_consts.vh ----
`ifndef MCRR_CONSTS_VH
`define MCRR_CONSTS_VH

// ****************************************************************
// operand select codes of the internal register file
// ****************************************************************
`define MCRR_SEL_AUX        5'h00
`define MCRR_SEL_JTA        5'h01
`define MCRR_SEL_JTB        5'h02
`define MCRR_SEL_CNT_A      5'h03
`define MCRR_SEL_CNT_B      5'h04
`define MCRR_SEL_CNT_C      5'h05
`define MCRR_SEL_CNT_D      5'h06
`define MCRR_SEL_EOC_A      5'h07
`define MCRR_SEL_EOC_B      5'h08
`define MCRR_SEL_EOC_C      5'h09
`define MCRR_SEL_EOC_D      5'h0a
`define MCRR_SEL_FLAG       5'h0b
`define MCRR_SEL_CTRL       5'h0c
`define MCRR_SEL_STATUS     5'h0d
`define MCRR_SEL_BKD_DATA   5'h0e
`define MCRR_SEL_DAC_SSSC   5'h0f
`define MCRR_SEL_DAC_OSSC   5'h10
`define MCRR_SEL_DAC_SSOC   5'h11
`define MCRR_SEL_DAC_OSOC   5'h12
`define MCRR_SEL_DAC_HN     5'h13
`define MCRR_SEL_BKD_ADDR   5'h14
`define MCRR_SEL_IRQ        5'h15
`define MCRR_SEL_EXCH       5'h16
`define MCRR_SEL_PC         5'h17

// ****************************************************************
// widths, reset values and control byte bit positions
// ****************************************************************
`define MCRR_ADDR_W         10
`define MCRR_PC_W           16
`define MCRR_DAC_W          14
`define MCRR_DAC_HN_W       12
`define MCRR_BKD_ADDR_W     8
`define MCRR_BASE_W         6
`define MCRR_RST_WORD       16'h0000
`define MCRR_RST_ADDR       10'h000
`define MCRR_RST_FLAG       16'hffff
`define MCRR_RST_BYTE       8'h00
`define MCRR_RST_DAC        14'h0000
`define MCRR_RST_DAC_HN     12'h000
`define MCRR_RST_BASE       6'h00
`define MCRR_LO_BYTE_MSB    7
`define MCRR_HI_BYTE_LSB    8

`endif

// ---- rtl/mcrr_resource_regs.v ----
// Overview of operation
// - interrupt entry saves pc into return register
// - interrupt return reloads pc or entry point
// - return register hidden from all operands
// - subroutine call saves return address
// - subroutine return loads pc from saved address
// - subroutine return address readable by copy/store
// - two far jump targets loadable before use
// - far jump takes selected target register
// - four private 16-bit counters per core
// - counter wraps from maximum to zero
// - counters a,b every clock; c,d prescaled
// - counters written by copy/load, readable
// - counter stops at end value, raises terminal
// - terminal signals offered as wait conditions
// - end values writable and readable
// - sixteen flags, wired and across cores
// - core drives flags, reads combined word
// - low control byte host written, core read
// - high control byte mirror or status bits
// - status word core rw, host read only
// - backdoor data buffer loadable and readable
// - dac, address and base register widths
// - pc holds next address, increments on fetch
`timescale 1ns/10ps
`default_nettype none
`include "mcrr_consts.vh"

module mcrr_resource_regs #(
  parameter PRESCALE_W = 16,
  parameter NUM_CORES  = 4
) (
  input  wire                             CLK_SYS_IN,
  input  wire                             RST_IN,
  // decoder side
  input  wire                             FETCH_IN,
  input  wire                             INT_ENTRY_IN,
  input  wire                             INT_RETURN_IN,
  input  wire                             INT_RET_ENTRY_SEL_IN,
  input  wire [`MCRR_PC_W-1:0]            ENTRY_POINT_IN,
  input  wire                             CALL_IN,
  input  wire [`MCRR_ADDR_W-1:0]          CALL_TARGET_IN,
  input  wire                             SUB_RETURN_IN,
  input  wire                             FAR_JUMP_IN,
  input  wire                             FAR_JUMP_SEL_IN,
  input  wire                             NEAR_JUMP_IN,
  input  wire [`MCRR_PC_W-1:0]            NEAR_TARGET_IN,
  input  wire                             WR_EN_IN,
  input  wire [4:0]                       WR_SEL_IN,
  input  wire [15:0]                      WR_DATA_IN,
  input  wire [4:0]                       RD_SEL_IN,
  output reg  [15:0]                      RD_DATA_OUT,
  input  wire                             FLAG_SET_IN,
  input  wire [15:0]                      FLAG_MASK_IN,
  input  wire [15:0]                      FLAG_VALUE_IN,
  input  wire                             CTRL_BIT_SET_IN,
  input  wire [2:0]                       CTRL_BIT_IDX_IN,
  input  wire                             CTRL_BIT_VAL_IN,
  input  wire                             BASE_WR_IN,
  input  wire [`MCRR_BASE_W-1:0]          BASE_DATA_IN,
  input  wire [1:0]                       WAIT_TC_SEL_IN,
  output wire                             WAIT_TC_OUT,
  output wire [3:0]                       TERMINAL_OUT,
  output reg  [`MCRR_PC_W-1:0]            PC_OUT,
  output reg  [`MCRR_BASE_W-1:0]          DATA_RAM_BASE_OUT,
  // system side
  input  wire [PRESCALE_W-1:0]            PRESCALE_C_IN,
  input  wire [PRESCALE_W-1:0]            PRESCALE_D_IN,
  input  wire                             CTRL_SPLIT_STATUS_IN,
  input  wire [16*(NUM_CORES-1)-1:0]      PEER_FLAGS_IN,
  output reg  [15:0]                      OWN_FLAGS_OUT,
  input  wire [15:0]                      IRQ_FLAGS_IN,
  input  wire                             BKD_RX_VALID_IN,
  input  wire [15:0]                      BKD_RX_DATA_IN,
  output reg  [15:0]                      BKD_DATA_OUT,
  output reg  [`MCRR_BKD_ADDR_W-1:0]      BKD_ADDR_OUT,
  // host side
  input  wire                             HOST_CTRL_WR_IN,
  input  wire                             HOST_CTRL_HI_WR_IN,
  input  wire [15:0]                      HOST_CTRL_DATA_IN,
  output wire [15:0]                      HOST_CTRL_OUT,
  output wire [15:0]                      HOST_STATUS_OUT,
  output wire [`MCRR_DAC_W*4-1:0]         DAC_OUT,
  output wire [`MCRR_DAC_HN_W-1:0]        DAC_HN_OUT
);

  // ****************************************************************
  // storage
  // ****************************************************************
  reg  [`MCRR_ADDR_W-1:0]   int_ret;
  reg  [`MCRR_ADDR_W-1:0]   sub_ret;
  reg  [`MCRR_ADDR_W-1:0]   jta;
  reg  [`MCRR_ADDR_W-1:0]   jtb;
  reg  [15:0]               cnt [0:3];
  reg  [15:0]               eoc [0:3];
  reg  [15:0]               ctrl_word;
  reg  [15:0]               status_word;
  reg  [15:0]               exch_word;
  reg  [`MCRR_DAC_W-1:0]    dac [0:3];
  reg  [`MCRR_DAC_HN_W-1:0] dac_hn;
  reg  [PRESCALE_W-1:0]     pre_c;
  reg  [PRESCALE_W-1:0]     pre_d;
  reg  [15:0]               flag_and;
  wire [3:0]                tick;
  wire [`MCRR_ADDR_W-1:0]   pc_low;

  assign pc_low = PC_OUT[`MCRR_ADDR_W-1:0];

  // ****************************************************************
  // program counter and return registers
  // ****************************************************************
  // priority: returns, then jumps, then plain fetch increment
  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PC_OUT  <= `MCRR_RST_WORD;
      int_ret <= `MCRR_RST_ADDR;
      sub_ret <= `MCRR_RST_ADDR;
    end else begin
      if (INT_ENTRY_IN) begin
        int_ret <= pc_low;
      end
      if (CALL_IN) begin
        sub_ret <= pc_low;
      end
      if (INT_RETURN_IN) begin
        if (INT_RET_ENTRY_SEL_IN) begin
          PC_OUT <= ENTRY_POINT_IN;
        end else begin
          PC_OUT <= {6'h00, int_ret};
        end
      end else if (SUB_RETURN_IN) begin
        PC_OUT <= {6'h00, sub_ret};
      end else if (FAR_JUMP_IN) begin
        PC_OUT <= {6'h00, FAR_JUMP_SEL_IN ? jtb : jta};
      end else if (CALL_IN) begin
        PC_OUT <= {6'h00, CALL_TARGET_IN};
      end else if (NEAR_JUMP_IN) begin
        PC_OUT <= NEAR_TARGET_IN;
      end else if (FETCH_IN) begin
        PC_OUT <= PC_OUT + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // counters
  // ****************************************************************
  // prescaler for c and d; a value of zero or one means every clock
  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pre_c <= {PRESCALE_W{1'b0}};
      pre_d <= {PRESCALE_W{1'b0}};
    end else begin
      pre_c <= (pre_c + 1'b1 >= PRESCALE_C_IN) ? {PRESCALE_W{1'b0}} : pre_c + 1'b1;
      pre_d <= (pre_d + 1'b1 >= PRESCALE_D_IN) ? {PRESCALE_W{1'b0}} : pre_d + 1'b1;
    end
  end

  assign tick[0] = 1'b1;
  assign tick[1] = 1'b1;
  assign tick[2] = (pre_c + 1'b1 >= PRESCALE_C_IN);
  assign tick[3] = (pre_d + 1'b1 >= PRESCALE_D_IN);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cnt
      // each core owns its four counters; compare stops the count
      assign TERMINAL_OUT[gi] = (cnt[gi] == eoc[gi]);
      always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
          cnt[gi] <= `MCRR_RST_WORD;
          eoc[gi] <= `MCRR_RST_WORD;
          dac[gi] <= `MCRR_RST_DAC;
        end else begin
          // select compared at full integer width so no bits are dropped
          if (WR_EN_IN && {27'h0, WR_SEL_IN} == `MCRR_SEL_CNT_A + gi) begin
            cnt[gi] <= WR_DATA_IN;
          end else if (!TERMINAL_OUT[gi] && tick[gi]) begin
            cnt[gi] <= cnt[gi] + 16'h0001;
          end
          if (WR_EN_IN && {27'h0, WR_SEL_IN} == `MCRR_SEL_EOC_A + gi) begin
            eoc[gi] <= WR_DATA_IN;
          end
          if (WR_EN_IN && {27'h0, WR_SEL_IN} == `MCRR_SEL_DAC_SSSC + gi) begin
            dac[gi] <= WR_DATA_IN[`MCRR_DAC_W-1:0];
          end
        end
      end
      assign DAC_OUT[gi*`MCRR_DAC_W +: `MCRR_DAC_W] = dac[gi];
    end
  endgenerate

  assign WAIT_TC_OUT = TERMINAL_OUT[WAIT_TC_SEL_IN];

  // ****************************************************************
  // shared flags
  // ****************************************************************
  // zero from any core dominates the combined word
  integer fi;
  always @* begin
    flag_and = OWN_FLAGS_OUT;
    for (fi = 0; fi < NUM_CORES-1; fi = fi + 1) begin
      flag_and = flag_and & PEER_FLAGS_IN[fi*16 +: 16];
    end
  end

  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      OWN_FLAGS_OUT <= `MCRR_RST_FLAG;
    end else if (FLAG_SET_IN) begin
      OWN_FLAGS_OUT <= (OWN_FLAGS_OUT & ~FLAG_MASK_IN) | (FLAG_VALUE_IN & FLAG_MASK_IN);
    end
  end

  // ****************************************************************
  // other writable registers
  // ****************************************************************
  // host owns the low control byte; the high byte is host or core
  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      jta               <= `MCRR_RST_ADDR;
      jtb               <= `MCRR_RST_ADDR;
      ctrl_word         <= `MCRR_RST_WORD;
      status_word       <= `MCRR_RST_WORD;
      exch_word         <= `MCRR_RST_WORD;
      BKD_DATA_OUT      <= `MCRR_RST_WORD;
      BKD_ADDR_OUT      <= `MCRR_RST_BYTE;
      dac_hn            <= `MCRR_RST_DAC_HN;
      DATA_RAM_BASE_OUT <= `MCRR_RST_BASE;
    end else begin
      if (HOST_CTRL_WR_IN) begin
        ctrl_word[`MCRR_LO_BYTE_MSB:0] <= HOST_CTRL_DATA_IN[7:0];
      end
      if (CTRL_SPLIT_STATUS_IN) begin
        if (CTRL_BIT_SET_IN) begin
          ctrl_word[`MCRR_HI_BYTE_LSB + CTRL_BIT_IDX_IN] <= CTRL_BIT_VAL_IN;
        end
      end else if (HOST_CTRL_HI_WR_IN) begin
        ctrl_word[15:`MCRR_HI_BYTE_LSB] <= HOST_CTRL_DATA_IN[15:8];
      end
      if (BKD_RX_VALID_IN) begin
        BKD_DATA_OUT <= BKD_RX_DATA_IN;
      end
      if (BASE_WR_IN) begin
        DATA_RAM_BASE_OUT <= BASE_DATA_IN;
      end
      // core write path; read-only words ignore their codes
      if (WR_EN_IN) begin
        case (WR_SEL_IN)
          `MCRR_SEL_JTA:      jta <= WR_DATA_IN[`MCRR_ADDR_W-1:0];
          `MCRR_SEL_JTB:      jtb <= WR_DATA_IN[`MCRR_ADDR_W-1:0];
          `MCRR_SEL_STATUS:   status_word <= WR_DATA_IN;
          `MCRR_SEL_BKD_DATA: BKD_DATA_OUT <= WR_DATA_IN;
          `MCRR_SEL_BKD_ADDR: BKD_ADDR_OUT <= WR_DATA_IN[7:0];
          `MCRR_SEL_DAC_HN:   dac_hn <= WR_DATA_IN[`MCRR_DAC_HN_W-1:0];
          `MCRR_SEL_EXCH:     exch_word <= WR_DATA_IN;
          default:            exch_word <= exch_word;
        endcase
      end
    end
  end

  assign HOST_CTRL_OUT   = ctrl_word;
  assign HOST_STATUS_OUT = status_word;
  assign DAC_HN_OUT      = dac_hn;

  // ****************************************************************
  // read multiplexer
  // ****************************************************************
  // interrupt return register has no code here on purpose
  always @* begin
    case (RD_SEL_IN)
      `MCRR_SEL_AUX:      RD_DATA_OUT = {6'h00, sub_ret};
      `MCRR_SEL_JTA:      RD_DATA_OUT = {6'h00, jta};
      `MCRR_SEL_JTB:      RD_DATA_OUT = {6'h00, jtb};
      `MCRR_SEL_CNT_A:    RD_DATA_OUT = cnt[0];
      `MCRR_SEL_CNT_B:    RD_DATA_OUT = cnt[1];
      `MCRR_SEL_CNT_C:    RD_DATA_OUT = cnt[2];
      `MCRR_SEL_CNT_D:    RD_DATA_OUT = cnt[3];
      `MCRR_SEL_EOC_A:    RD_DATA_OUT = eoc[0];
      `MCRR_SEL_EOC_B:    RD_DATA_OUT = eoc[1];
      `MCRR_SEL_EOC_C:    RD_DATA_OUT = eoc[2];
      `MCRR_SEL_EOC_D:    RD_DATA_OUT = eoc[3];
      `MCRR_SEL_FLAG:     RD_DATA_OUT = flag_and;
      `MCRR_SEL_CTRL:     RD_DATA_OUT = ctrl_word;
      `MCRR_SEL_STATUS:   RD_DATA_OUT = status_word;
      `MCRR_SEL_BKD_DATA: RD_DATA_OUT = BKD_DATA_OUT;
      `MCRR_SEL_DAC_SSSC: RD_DATA_OUT = {2'b00, dac[0]};
      `MCRR_SEL_DAC_OSSC: RD_DATA_OUT = {2'b00, dac[1]};
      `MCRR_SEL_DAC_SSOC: RD_DATA_OUT = {2'b00, dac[2]};
      `MCRR_SEL_DAC_OSOC: RD_DATA_OUT = {2'b00, dac[3]};
      `MCRR_SEL_DAC_HN:   RD_DATA_OUT = {4'h0, dac_hn};
      `MCRR_SEL_BKD_ADDR: RD_DATA_OUT = {8'h00, BKD_ADDR_OUT};
      `MCRR_SEL_IRQ:      RD_DATA_OUT = IRQ_FLAGS_IN;
      `MCRR_SEL_EXCH:     RD_DATA_OUT = exch_word;
      `MCRR_SEL_PC:       RD_DATA_OUT = PC_OUT;
      default:            RD_DATA_OUT = 16'h0000;
    endcase
  end

endmodule // mcrr_resource_regs
`default_nettype wire

// ---- test/mcrr_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mcrr_consts.vh"
// ****************************************************************
// port checker: program counter, counter a and flag word
// ****************************************************************
module mcrr_chk #(
  parameter PRESCALE_W = 16,
  parameter NUM_CORES  = 4
) (
  input wire logic                         CLK_SYS_IN,
  input wire logic                         RST_IN,
  input wire logic                         FETCH_IN,
  input wire logic                         INT_RETURN_IN,
  input wire logic                         INT_RET_ENTRY_SEL_IN,
  input wire logic [15:0]                  ENTRY_POINT_IN,
  input wire logic                         CALL_IN,
  input wire logic                         SUB_RETURN_IN,
  input wire logic                         FAR_JUMP_IN,
  input wire logic                         FAR_JUMP_SEL_IN,
  input wire logic                         NEAR_JUMP_IN,
  input wire logic                         WR_EN_IN,
  input wire logic [4:0]                   WR_SEL_IN,
  input wire logic [4:0]                   RD_SEL_IN,
  input wire logic [15:0]                  RD_DATA_OUT,
  input wire logic [1:0]                   WAIT_TC_SEL_IN,
  input wire logic                         WAIT_TC_OUT,
  input wire logic [3:0]                   TERMINAL_OUT,
  input wire logic [15:0]                  PC_OUT,
  input wire logic [15:0]                  OWN_FLAGS_OUT,
  input wire logic [16*(NUM_CORES-1)-1:0]  PEER_FLAGS_IN
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  // strobes that outrank a call or fetch; the flag check assumes four cores
  wire logic       hi_pc = INT_RETURN_IN | SUB_RETURN_IN | FAR_JUMP_IN;
  wire logic       a_wr  = WR_EN_IN & (WR_SEL_IN == `MCRR_SEL_CNT_A | WR_SEL_IN == `MCRR_SEL_EOC_A);
  wire logic [9:0] pc_lo = PC_OUT[9:0];
  wire logic [9:0] rd_lo = RD_DATA_OUT[9:0];
  a_call_saves_pc: assert property ((CALL_IN && !hi_pc) ##1 (RD_SEL_IN == `MCRR_SEL_AUX) |-> RD_DATA_OUT == {6'h00, $past(pc_lo)}) else $error("call did not save pc");
  a_sub_ret_load: assert property (SUB_RETURN_IN && !INT_RETURN_IN && RD_SEL_IN == `MCRR_SEL_AUX |=> PC_OUT == {6'h00, $past(rd_lo)}) else $error("subroutine return target wrong");
  a_entry_point: assert property (INT_RETURN_IN && INT_RET_ENTRY_SEL_IN |=> PC_OUT == $past(ENTRY_POINT_IN)) else $error("entry point not taken");
  a_fetch_incr: assert property (FETCH_IN && !hi_pc && !CALL_IN && !NEAR_JUMP_IN |=> PC_OUT == $past(PC_OUT) + 16'h0001) else $error("fetch did not step pc");
  a_far_jump_b: assert property (FAR_JUMP_IN && FAR_JUMP_SEL_IN && !INT_RETURN_IN && !SUB_RETURN_IN && RD_SEL_IN == `MCRR_SEL_JTB |=> PC_OUT == {6'h00, $past(rd_lo)}) else $error("far jump target wrong");
  a_wait_tc_mux: assert property (WAIT_TC_OUT == TERMINAL_OUT[WAIT_TC_SEL_IN]) else $error("wait condition select wrong");
  a_count_step: assert property ((RD_SEL_IN == `MCRR_SEL_CNT_A && !TERMINAL_OUT[0] && !a_wr) ##1 (RD_SEL_IN == `MCRR_SEL_CNT_A) |-> RD_DATA_OUT == $past(RD_DATA_OUT) + 16'h0001) else $error("counter did not step");
  a_count_hold: assert property ((RD_SEL_IN == `MCRR_SEL_CNT_A && TERMINAL_OUT[0] && !a_wr) ##1 (RD_SEL_IN == `MCRR_SEL_CNT_A) |-> $stable(RD_DATA_OUT)) else $error("counter ran past end value");
  a_flag_and: assert property (RD_SEL_IN == `MCRR_SEL_FLAG |-> RD_DATA_OUT == (OWN_FLAGS_OUT & PEER_FLAGS_IN[15:0] & PEER_FLAGS_IN[31:16] & PEER_FLAGS_IN[47:32])) else $error("flag word not anded");
endmodule // mcrr_chk
bind mcrr_resource_regs mcrr_chk #(.PRESCALE_W(PRESCALE_W), .NUM_CORES(NUM_CORES)) u_chk (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .FETCH_IN(FETCH_IN), .INT_RETURN_IN(INT_RETURN_IN),
  .INT_RET_ENTRY_SEL_IN(INT_RET_ENTRY_SEL_IN), .ENTRY_POINT_IN(ENTRY_POINT_IN), .CALL_IN(CALL_IN),
  .SUB_RETURN_IN(SUB_RETURN_IN), .FAR_JUMP_IN(FAR_JUMP_IN), .FAR_JUMP_SEL_IN(FAR_JUMP_SEL_IN),
  .NEAR_JUMP_IN(NEAR_JUMP_IN), .WR_EN_IN(WR_EN_IN), .WR_SEL_IN(WR_SEL_IN), .RD_SEL_IN(RD_SEL_IN),
  .RD_DATA_OUT(RD_DATA_OUT), .WAIT_TC_SEL_IN(WAIT_TC_SEL_IN), .WAIT_TC_OUT(WAIT_TC_OUT),
  .TERMINAL_OUT(TERMINAL_OUT), .PC_OUT(PC_OUT), .OWN_FLAGS_OUT(OWN_FLAGS_OUT),
  .PEER_FLAGS_IN(PEER_FLAGS_IN));
`default_nettype wire

// ---- test/mcrr_peer_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// peer cores: flag contributions of the other three microcores
// ****************************************************************
module mcrr_peer_model #(
  parameter int PEERS = 3
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 load_in,
  input  wire logic [16*PEERS-1:0]  flags_in,
  output var  logic [16*PEERS-1:0]  flags_out
);
  // every peer holds its contribution until load_in reloads all three at once
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) flags_out <= '1;
    else if (load_in) flags_out <= flags_in;
  end
endmodule // mcrr_peer_model
`default_nettype wire

// ---- test/mcrr_resource_regs_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mcrr_consts.vh"
// ****************************************************************
// self-checking bench: strobes pulse one cycle, one idle cycle apart
// ****************************************************************
module mcrr_resource_regs_test;
  localparam int s_fe = 0, s_ie = 1, s_ir = 2, s_ca = 3, s_sr = 4, s_fj = 5, s_we = 6, s_fs = 7;
  localparam int s_cb = 8, s_bw = 9, s_rx = 10, s_hw = 11, s_hh = 12, s_nj = 13, s_pl = 14;
  logic        clk = 1'b0, rst = 1'b1, ensel = 1'b0, fjsel = 1'b0, cval = 1'b0, split = 1'b0, wtc;
  logic [14:0] stb = '0;
  logic [15:0] entry = '0, ntgt = '0, wdat = '0, fmask = '0, fval = '0, prc = 16'h0003;
  logic [15:0] irq = '0, rxd = '0, hdat = '0, rdat, pc, own, bko, hco, hso, v, e, xp;
  logic [15:0] prd = 16'h0002;
  logic [9:0]  ctgt = '0;
  logic [1:0]  tsel = '0;
  logic [55:0] dao;
  logic [11:0] dhn;
  logic [7:0]  bka;
  logic [4:0]  wsel = '0, rsel = '0;
  logic [5:0]  bdat = '0, base;
  logic [2:0]  cidx = '0;
  logic [47:0] pin = '0, peer;
  logic [3:0]  term;
  logic [31:0] seed = 32'h4184;
  logic [4:0]  rwl [13] = '{`MCRR_SEL_JTA, `MCRR_SEL_JTB, `MCRR_SEL_EOC_B, `MCRR_SEL_EOC_D,
    `MCRR_SEL_STATUS, `MCRR_SEL_BKD_DATA, `MCRR_SEL_DAC_SSSC, `MCRR_SEL_DAC_OSSC,
    `MCRR_SEL_DAC_SSOC, `MCRR_SEL_DAC_OSOC, `MCRR_SEL_DAC_HN, `MCRR_SEL_BKD_ADDR, `MCRR_SEL_EXCH};
  int          n_fail = 0, cmp_count = 0;
  always #20 clk = ~clk;
  mcrr_peer_model u_peer (.clk_in(clk), .rst_in(rst), .load_in(stb[s_pl]), .flags_in(pin),
    .flags_out(peer));
  mcrr_resource_regs DUT (.CLK_SYS_IN(clk), .RST_IN(rst), .FETCH_IN(stb[s_fe]),
    .INT_ENTRY_IN(stb[s_ie]), .INT_RETURN_IN(stb[s_ir]), .INT_RET_ENTRY_SEL_IN(ensel),
    .ENTRY_POINT_IN(entry), .CALL_IN(stb[s_ca]), .CALL_TARGET_IN(ctgt), .SUB_RETURN_IN(stb[s_sr]),
    .FAR_JUMP_IN(stb[s_fj]), .FAR_JUMP_SEL_IN(fjsel), .NEAR_JUMP_IN(stb[s_nj]), .NEAR_TARGET_IN(ntgt),
    .WR_EN_IN(stb[s_we]), .WR_SEL_IN(wsel), .WR_DATA_IN(wdat), .RD_SEL_IN(rsel), .RD_DATA_OUT(rdat),
    .FLAG_SET_IN(stb[s_fs]), .FLAG_MASK_IN(fmask), .FLAG_VALUE_IN(fval), .CTRL_BIT_SET_IN(stb[s_cb]),
    .CTRL_BIT_IDX_IN(cidx), .CTRL_BIT_VAL_IN(cval), .BASE_WR_IN(stb[s_bw]), .BASE_DATA_IN(bdat),
    .WAIT_TC_SEL_IN(tsel), .WAIT_TC_OUT(wtc), .TERMINAL_OUT(term), .PC_OUT(pc),
    .DATA_RAM_BASE_OUT(base), .PRESCALE_C_IN(prc), .PRESCALE_D_IN(prd),
    .CTRL_SPLIT_STATUS_IN(split), .PEER_FLAGS_IN(peer), .OWN_FLAGS_OUT(own), .IRQ_FLAGS_IN(irq),
    .BKD_RX_VALID_IN(stb[s_rx]), .BKD_RX_DATA_IN(rxd), .BKD_DATA_OUT(bko), .BKD_ADDR_OUT(bka),
    .HOST_CTRL_WR_IN(stb[s_hw]), .HOST_CTRL_HI_WR_IN(stb[s_hh]), .HOST_CTRL_DATA_IN(hdat),
    .HOST_CTRL_OUT(hco), .HOST_STATUS_OUT(hso), .DAC_OUT(dao), .DAC_HN_OUT(dhn));
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  // narrower registers read back zero-extended
  function automatic logic [15:0] wmask(input logic [4:0] s);
    case (s)
      `MCRR_SEL_JTA, `MCRR_SEL_JTB: return 16'h03ff;
      `MCRR_SEL_DAC_SSSC, `MCRR_SEL_DAC_OSSC, `MCRR_SEL_DAC_SSOC, `MCRR_SEL_DAC_OSOC: return 16'h3fff;
      `MCRR_SEL_DAC_HN: return 16'h0fff;
      `MCRR_SEL_BKD_ADDR: return 16'h00ff;
      default: return 16'hffff;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobe; the idle cycle after it keeps drivers single per time step
  task automatic pulse(input int a, input int b = -1);
    logic [14:0] t;
    t = '0;
    t[a] = 1'b1;
    if (b >= 0) t[b] = 1'b1;
    @(negedge clk) stb = t;
    @(negedge clk) stb = '0;
  endtask
  // select and data change with the strobe, on the falling edge
  task automatic wr(input logic [4:0] s, input logic [15:0] d);
    @(negedge clk);
    wsel = s;
    wdat = d;
    stb = 15'h0001 << s_we;
    @(negedge clk) stb = '0;
  endtask
  // returns on a falling edge so that later stimulus stays edge aligned
  task automatic rd(input logic [4:0] s, output logic [15:0] r);
    @(negedge clk) rsel = s;
    #1 r = rdat;
    @(negedge clk);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check(pc, 16'h0000);
    check(own, 16'hffff);
    wr(`MCRR_SEL_CTRL, 16'hffff);
    rd(`MCRR_SEL_CTRL, v);
    check(v, 16'h0000);
    wr(`MCRR_SEL_AUX, 16'hffff);
    rd(`MCRR_SEL_AUX, v);
    check(v, 16'h0000);
    foreach (rwl[i]) begin
      e = rnd();
      wr(rwl[i], e);
      rd(rwl[i], v);
      check(v, e & wmask(rwl[i]));
    end
    check(hco, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      e = rnd();
      wr(5'(`MCRR_SEL_DAC_SSSC + i), e);
      check({2'b00, dao[i*14 +: 14]}, e & 16'h3fff);
    end
    wr(`MCRR_SEL_DAC_HN, 16'hf5a3);
    check({4'h0, dhn}, 16'h05a3);
    wr(`MCRR_SEL_BKD_ADDR, 16'hc35a);
    check({8'h00, bka}, 16'h005a);
    e = rnd();
    wr(`MCRR_SEL_STATUS, e);
    check(hso, e);
    $display("test register set done");
    repeat (3) pulse(s_fe);
    check(pc, 16'h0003);
    e = rnd();
    ctgt = e[9:0];
    rsel = `MCRR_SEL_AUX;
    pulse(s_ca, s_fe);
    check(pc, {6'h00, ctgt});
    rd(`MCRR_SEL_AUX, v);
    check(v, 16'h0003);
    pulse(s_sr);
    check(pc, 16'h0003);
    for (int s = 0; s < 2; s++) begin
      e = rnd();
      wr(s ? `MCRR_SEL_JTB : `MCRR_SEL_JTA, e);
      fjsel = s[0];
      rsel = fjsel ? `MCRR_SEL_JTB : `MCRR_SEL_JTA;
      pulse(s_fj);
      xp = e & 16'h03ff;
      check(pc, xp);
    end
    pulse(s_ie);
    pulse(s_fe);
    pulse(s_ir);
    check(pc, xp);
    entry = rnd();
    ensel = 1'b1;
    pulse(s_ir);
    check(pc, entry);
    ntgt = rnd();
    pulse(s_nj);
    check(pc, ntgt);
    $display("test program counter done");
    // counter a wraps through zero, stops at its end value, resumes on rewrite
    rsel = `MCRR_SEL_CNT_A;
    wr(`MCRR_SEL_EOC_A, 16'h0002);
    wr(`MCRR_SEL_CNT_A, 16'hfffe);
    repeat (4) @(negedge clk);
    #1 check(rdat, 16'h0002);
    check({15'h0000, term[0]}, 16'h0001);
    check({15'h0000, wtc}, 16'h0001);
    repeat (3) @(negedge clk);
    #1 check(rdat, 16'h0002);
    wr(`MCRR_SEL_EOC_A, 16'h0005);
    repeat (3) @(negedge clk);
    #1 check(rdat, 16'h0005);
    wr(`MCRR_SEL_EOC_C, 16'hffff);
    wr(`MCRR_SEL_EOC_D, 16'hffff);
    wr(`MCRR_SEL_CNT_C, 16'h0000);
    wr(`MCRR_SEL_CNT_D, 16'h0000);
    repeat (30) @(negedge clk);
    rd(`MCRR_SEL_CNT_C, v);
    check({15'h0000, v >= 16'd9 && v <= 16'd11}, 16'h0001);
    rd(`MCRR_SEL_CNT_D, v);
    check({15'h0000, v >= 16'd16 && v <= 16'd17}, 16'h0001);
    tsel = 2'h2;
    #1 check({15'h0000, wtc}, 16'h0000);
    rd(`MCRR_SEL_CNT_A, v);
    check(v, 16'h0005);
    $display("test counters done");
    pin = {rnd(), rnd(), rnd()};
    fmask = 16'hffff;
    fval = rnd();
    e = fval;
    pulse(s_fs, s_pl);
    rd(`MCRR_SEL_FLAG, v);
    check(v, fval & pin[15:0] & pin[31:16] & pin[47:32]);
    fmask = 16'h00ff;
    fval = 16'h0000;
    pulse(s_fs);
    check(own, {e[15:8], 8'h00});
    hdat = rnd();
    pulse(s_hw, s_hh);
    rd(`MCRR_SEL_CTRL, v);
    check(v, hdat);
    e = hdat;
    v = rnd();
    cidx = v[2:0];
    cval = ~e[8 + cidx];
    e[8 + cidx] = cval;
    split = 1'b1;
    pulse(s_cb);
    hdat = ~hdat;
    pulse(s_hh);
    check(hco, e);
    rxd = rnd();
    pulse(s_rx);
    check(bko, rxd);
    e = rnd();
    bdat = e[5:0];
    pulse(s_bw);
    check({10'h000, base}, {10'h000, bdat});
    irq = rnd();
    rd(`MCRR_SEL_IRQ, v);
    check(v, irq);
    $display("test shared words done");
    finish_test;
  end
endmodule // mcrr_resource_regs_test
`default_nettype wire
